// >>> core/ivt_pkg.sv
// Constants, register map and types of the interrupt vector and trap unit
package ivt_pkg;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int SEG_W     = 8;
  localparam int OFS_W     = 16;
  localparam int TNUM_W    = 7;
  localparam int LVL_W     = 4;
  localparam int NUM_NODES = 8;
  localparam int NIDX_W    = 3;
  localparam int NUM_TRAPS = 8;
  localparam int NUM_CLS_A = 4;
  localparam int NUM_EVT   = 2;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADR_VSEG     = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_CPUCFG1  = 8'h02;
  localparam logic [ADDR_W-1:0] ADR_TRAPFLAG = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_IRQSTAT  = 8'h06;
  localparam logic [ADDR_W-1:0] ADR_IRQMASK  = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_NODE0    = 8'h10;
  localparam logic [ADDR_W-1:0] ADR_NODE_STP = 8'h02;

  // Field layout
  localparam int VSC_LSB  = 0;
  localparam int VSC_W    = 2;
  localparam int NREQ_BIT = 7;
  localparam int NEN_BIT  = 6;
  localparam int NLVL_LSB = 0;
  localparam int EVT_TRAP = 0;
  localparam int EVT_INT  = 1;

  // Reset values
  localparam logic [SEG_W-1:0]   VSEG_RST   = 8'h00;
  localparam logic [VSC_W-1:0]   VSC_RST    = 2'h0;
  localparam logic [NUM_EVT-1:0] MASK_RST   = 2'h0;
  // Shift of the trap number for spacing code 0: 4 bytes, two words
  localparam int                 SPC_SHIFT  = 2;

  // Hardware trap numbers, flag index 0..3 class A, 4..7 share class B
  localparam logic [NUM_TRAPS-1:0][TNUM_W-1:0] HW_TRAP_NUM = {
    7'h0a, 7'h0a, 7'h0a, 7'h0a, 7'h08, 7'h06, 7'h04, 7'h02};

  // Node trap numbers: unassigned 57..54, end of subchannel 4c, timers and receive
  localparam logic [NUM_NODES-1:0][TNUM_W-1:0] NODE_TRAP_NUM = {
    7'h57, 7'h56, 7'h55, 7'h54, 7'h4c, 7'h2b, 7'h21, 7'h20};

  typedef enum logic [1:0] {
    TCLS_NONE = 2'b00,
    TCLS_B    = 2'b01,
    TCLS_A    = 2'b10
  } trap_cls_e;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_OFFER = 1'b1
  } vec_state_e;
endpackage

// >>> core/node_ctrl.sv
// Control register of one interrupt node: request, enable, priority level
`timescale 1ns/1ps
module node_ctrl
  import ivt_pkg::*;
(
  input  wire logic             clk,      // System clock
  input  wire logic             reset_n,  // Async reset
  input  wire logic             wr,       // Write to this node register
  input  wire logic [DATA_W-1:0] wdata,   // Write data
  input  wire logic             hw_req,   // Peripheral request pulse
  input  wire logic             ack_clr,  // Vector taken by the core
  output logic                  req,      // Request flag
  output logic                  en,       // Enable flag
  output logic [LVL_W-1:0]      lvl       // Priority level
);
  import ivt_pkg::*;

  typedef struct packed {
    logic             req;
    logic             en;
    logic [LVL_W-1:0] lvl;
  } node_s;

  node_s st_r;
  node_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (ack_clr) begin
      st_nxt.req = 1'b0;
    end
    if (wr) begin
      st_nxt.req = wdata[NREQ_BIT];
      st_nxt.en  = wdata[NEN_BIT];
      st_nxt.lvl = wdata[NLVL_LSB +: LVL_W];
    end
    // Hardware request wins over a clear in the same cycle
    if (hw_req) begin
      st_nxt.req = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign req = st_r.req;
  assign en  = st_r.en;
  assign lvl = st_r.lvl;
endmodule

// >>> core/interrupt_vector_trap_unit.sv
// Vector generation, node arbitration and hardware trap handling
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module interrupt_vector_trap_unit
  import ivt_pkg::*;
(
  input  wire logic                          clk,          // System clock, 100 MHz
  input  wire logic                          reset_n,      // Async reset, active low
  input  wire logic [ivt_pkg::ADDR_W-1:0]    addr,         // Register byte address
  input  wire logic [ivt_pkg::DATA_W-1:0]    wdata,        // Register write data
  input  wire logic                          wr_en,        // Write strobe
  input  wire logic                          rd_en,        // Read strobe
  output logic      [ivt_pkg::DATA_W-1:0]    rdata,        // Read data, cycle after rd_en
  input  wire logic [ivt_pkg::NUM_NODES-1:0] node_req_in,  // Peripheral request pulses
  input  wire logic [ivt_pkg::NUM_TRAPS-1:0] hw_trap_in,   // Hardware trap pulses
  input  wire logic [ivt_pkg::LVL_W-1:0]     cpu_level,    // Current CPU priority
  input  wire logic                          vector_ack,   // Core takes the vector
  input  wire logic                          trap_return,  // Core leaves trap service
  output logic                               vector_valid, // Vector offered
  output logic      [23:0]                   vector_addr,  // Segment and offset
  output logic      [ivt_pkg::TNUM_W-1:0]    vector_num,   // Trap number
  output logic                               vector_is_trap, // Offered vector is a trap
  output logic      [ivt_pkg::LVL_W-1:0]     vector_level, // Level of offered node
  output logic                               trap_active,  // Trap service running
  output logic                               xfer_block,   // Event transfers held off
  output logic                               irq           // Unmasked status pending
);
  import ivt_pkg::*;

  typedef struct packed {
    vec_state_e           st;
    logic [SEG_W-1:0]     vseg;
    logic [VSC_W-1:0]     vsc;
    logic [NUM_TRAPS-1:0] tflag;
    logic [NUM_TRAPS-1:0] tpend;
    trap_cls_e            tcls;
    logic [NUM_EVT-1:0]   istat;
    logic [NUM_EVT-1:0]   imask;
    logic [DATA_W-1:0]    rdata;
    logic [23:0]          vaddr;
    logic [TNUM_W-1:0]    vnum;
    logic                 vtrap;
    logic [LVL_W-1:0]     vlvl;
    trap_cls_e            vcls;
    logic [NIDX_W-1:0]    vnode;
  } unit_s;

  unit_s st_r;
  unit_s st_nxt;

  logic [NUM_NODES-1:0]            n_req;
  logic [NUM_NODES-1:0]            n_en;
  logic [NUM_NODES-1:0][LVL_W-1:0] n_lvl;
  logic [NUM_NODES-1:0]            n_wr;
  logic [NUM_NODES-1:0]            n_ack;

  // Node selection
  logic              int_found;
  logic [NIDX_W-1:0] int_idx;
  logic [LVL_W-1:0]  int_lvl;
  // Trap selection
  logic              trap_found;
  logic [NIDX_W-1:0] trap_idx;
  trap_cls_e         trap_cls;
  logic              take;
  logic [NUM_EVT-1:0] evt;

  genvar g;
  generate
    for (g = 0; g < NUM_NODES; g++) begin : gen_node
      node_ctrl u_node (
        .clk     (clk),
        .reset_n (reset_n),
        .wr      (n_wr[g]),
        .wdata   (wdata),
        .hw_req  (node_req_in[g]),
        .ack_clr (n_ack[g]),
        .req     (n_req[g]),
        .en      (n_en[g]),
        .lvl     (n_lvl[g])
      );
    end
  endgenerate

  function automatic logic [ADDR_W-1:0] node_adr(input int i);
    node_adr = ADR_NODE0 + ADDR_W'(i) * ADR_NODE_STP;
  endfunction

  // Offset grows with the spacing code; table base from the segment
  function automatic logic [23:0] vec_of(input logic [SEG_W-1:0] seg,
                                         input logic [VSC_W-1:0] vsc,
                                         input logic [TNUM_W-1:0] num);
    logic [OFS_W-1:0] ofs;
    ofs    = OFS_W'(num) << (SPC_SHIFT + int'(vsc));
    vec_of = {seg, ofs};
  endfunction

  always_comb begin
    n_wr = '0;
    for (int i = 0; i < NUM_NODES; i++) begin
      n_wr[i] = wr_en && (addr == node_adr(i));
    end
  end

  // Highest level wins, ties go to the lower node index
  always_comb begin
    int_found = 1'b0;
    int_idx   = '0;
    int_lvl   = '0;
    for (int i = 0; i < NUM_NODES; i++) begin
      if (n_req[i] && n_en[i] && (n_lvl[i] > cpu_level)) begin
        if (!int_found || (n_lvl[i] > int_lvl)) begin
          int_found = 1'b1;
          int_idx   = NIDX_W'(i);
          int_lvl   = n_lvl[i];
        end
      end
    end
  end

  // Lowest flag index is the most urgent trap
  always_comb begin
    trap_found = 1'b0;
    trap_idx   = '0;
    for (int i = NUM_TRAPS - 1; i >= 0; i--) begin
      if (st_r.tpend[i]) begin
        trap_found = 1'b1;
        trap_idx   = NIDX_W'(i);
      end
    end
    trap_cls = (int'(trap_idx) < NUM_CLS_A) ? TCLS_A : TCLS_B;
  end

  assign take = (st_r.st == ST_OFFER) && vector_ack;

  always_comb begin
    st_nxt = st_r;
    n_ack  = '0;
    evt    = '0;

    // Register writes
    if (wr_en) begin
      if (addr == ADR_VSEG) begin
        st_nxt.vseg = wdata[SEG_W-1:0];
      end else if (addr == ADR_CPUCFG1) begin
        st_nxt.vsc = wdata[VSC_LSB +: VSC_W];
      end else if (addr == ADR_TRAPFLAG) begin
        st_nxt.tflag = st_r.tflag & ~wdata[NUM_TRAPS-1:0];
      end else if (addr == ADR_IRQSTAT) begin
        st_nxt.istat = st_r.istat & ~wdata[NUM_EVT-1:0];
      end else if (addr == ADR_IRQMASK) begin
        st_nxt.imask = wdata[NUM_EVT-1:0];
      end
    end

    // Read data stand only in the cycle after the strobe
    st_nxt.rdata = '0;
    if (rd_en) begin
      if (addr == ADR_VSEG) begin
        st_nxt.rdata = DATA_W'(st_r.vseg);
      end else if (addr == ADR_CPUCFG1) begin
        st_nxt.rdata = DATA_W'(st_r.vsc);
      end else if (addr == ADR_TRAPFLAG) begin
        st_nxt.rdata = DATA_W'(st_r.tflag);
      end else if (addr == ADR_IRQSTAT) begin
        st_nxt.rdata = DATA_W'(st_r.istat);
      end else if (addr == ADR_IRQMASK) begin
        st_nxt.rdata = DATA_W'(st_r.imask);
      end else begin
        for (int i = 0; i < NUM_NODES; i++) begin
          if (addr == node_adr(i)) begin
            st_nxt.rdata[NREQ_BIT]              = n_req[i];
            st_nxt.rdata[NEN_BIT]               = n_en[i];
            st_nxt.rdata[NLVL_LSB +: LVL_W]     = n_lvl[i];
          end
        end
      end
    end

    if (trap_return) begin
      st_nxt.tcls = TCLS_NONE;
    end

    case (st_r.st)
      ST_IDLE: begin
        // No mask or enable gates a pending trap
        if (trap_found && (trap_cls > st_r.tcls)) begin
          st_nxt.st    = ST_OFFER;
          st_nxt.vtrap = 1'b1;
          st_nxt.vnum  = HW_TRAP_NUM[trap_idx];
          st_nxt.vaddr = vec_of(st_r.vseg, st_r.vsc, HW_TRAP_NUM[trap_idx]);
          st_nxt.vlvl  = '0;
          st_nxt.vcls  = trap_cls;
          st_nxt.vnode = trap_idx;
        end else if (int_found && (st_r.tcls == TCLS_NONE)) begin
          st_nxt.st    = ST_OFFER;
          st_nxt.vtrap = 1'b0;
          st_nxt.vnum  = NODE_TRAP_NUM[int_idx];
          st_nxt.vaddr = vec_of(st_r.vseg, st_r.vsc, NODE_TRAP_NUM[int_idx]);
          st_nxt.vlvl  = int_lvl;
          st_nxt.vcls  = TCLS_NONE;
          st_nxt.vnode = int_idx;
        end
      end
      ST_OFFER: begin
        if (take) begin
          st_nxt.st = ST_IDLE;
          if (st_r.vtrap) begin
            st_nxt.tcls = st_r.vcls;
            evt[EVT_TRAP] = 1'b1;
            // Class B traps share one vector, so one entry serves them all
            if (st_r.vcls == TCLS_B) begin
              for (int i = NUM_CLS_A; i < NUM_TRAPS; i++) begin
                st_nxt.tpend[i] = 1'b0;
              end
            end else begin
              st_nxt.tpend[st_r.vnode] = 1'b0;
            end
          end else begin
            n_ack[st_r.vnode] = 1'b1;
            evt[EVT_INT]      = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.st = ST_IDLE;
      end
    endcase

    // New events win over clears in the same cycle
    st_nxt.tflag = st_nxt.tflag | hw_trap_in;
    st_nxt.tpend = st_nxt.tpend | hw_trap_in;
    st_nxt.istat = st_nxt.istat | evt;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r      <= '0;
      st_r.st   <= ST_IDLE;
      st_r.vseg <= VSEG_RST;
      st_r.vsc  <= VSC_RST;
      st_r.imask <= MASK_RST;
      st_r.tcls <= TCLS_NONE;
      st_r.vcls <= TCLS_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata          = st_r.rdata;
  assign vector_valid   = (st_r.st == ST_OFFER);
  assign vector_addr    = st_r.vaddr;
  assign vector_num     = st_r.vnum;
  assign vector_is_trap = st_r.vtrap;
  assign vector_level   = st_r.vlvl;
  assign trap_active    = (st_r.tcls != TCLS_NONE);
  assign xfer_block     = (st_r.tcls != TCLS_NONE);
  assign irq            = |(st_r.istat & st_r.imask);
endmodule

// >>> tb/ivt_chk.sv
// Port assertions of the vector and trap unit
`timescale 1ns/1ps
module ivt_chk (
  input wire logic                          clk,            // Clock
  input wire logic                          reset_n,        // Reset
  input wire logic [ivt_pkg::ADDR_W-1:0]    addr,           // Address
  input wire logic [ivt_pkg::DATA_W-1:0]    wdata,          // Data
  input wire logic                          wr_en,          // Write
  input wire logic [ivt_pkg::NUM_TRAPS-1:0] hw_trap_in,     // Traps
  input wire logic [ivt_pkg::LVL_W-1:0]     cpu_level,      // CPU level
  input wire logic                          vector_ack,     // Taken
  input wire logic                          trap_return,    // Return
  input wire logic                          vector_valid,   // Offer
  input wire logic [23:0]                   vector_addr,    // Vector
  input wire logic [ivt_pkg::TNUM_W-1:0]    vector_num,     // Number
  input wire logic                          vector_is_trap, // Trap offer
  input wire logic [ivt_pkg::LVL_W-1:0]     vector_level,   // Level
  input wire logic                          trap_active,    // Busy
  input wire logic                          xfer_block      // Held off
);
  import ivt_pkg::*;
  logic [SEG_W-1:0] seg_r;
  logic [VSC_W-1:0] vsc_r;
  // Shadow copies so the vector address can be judged from bus writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seg_r <= VSEG_RST;
      vsc_r <= VSC_RST;
    end else if (wr_en) begin
      if (addr == ADR_VSEG) seg_r <= wdata[SEG_W-1:0];
      if (addr == ADR_CPUCFG1) vsc_r <= wdata[VSC_W-1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_hold;
    vector_valid && !vector_ack |=> vector_valid && $stable(vector_addr)
      && $stable(vector_num);
  endproperty
  a_hold: assert property (p_hold)
    else $error("offered vector changed before take");
  property p_drop;
    vector_valid && vector_ack |=> !vector_valid;
  endproperty
  a_drop: assert property (p_drop)
    else $error("offer stayed after take");
  property p_addr;
    vector_valid |-> vector_addr == {seg_r, 16'(vector_num) << (SPC_SHIFT + vsc_r)};
  endproperty
  a_addr: assert property (p_addr)
    else $error("vector address wrong");
  property p_offer;
    hw_trap_in[0] && !trap_active && !vector_valid |-> ##[1:40]
      vector_valid && vector_is_trap && vector_num == HW_TRAP_NUM[0];
  endproperty
  a_offer: assert property (p_offer)
    else $error("trap not offered in time");
  property p_lvl;
    vector_valid && !vector_is_trap |-> vector_level > cpu_level;
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("node offered at too low a level");
  property p_blk;
    trap_active |-> !vector_valid || vector_is_trap;
  endproperty
  a_blk: assert property (p_blk)
    else $error("node offered during trap service");
  property p_xfer;
    xfer_block == trap_active;
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("transfer block differs from trap service");
  property p_enter;
    vector_valid && vector_is_trap && vector_ack |=> trap_active;
  endproperty
  a_enter: assert property (p_enter)
    else $error("trap taken but service not active");
  property p_nest;
    vector_valid && vector_is_trap && trap_active |-> vector_num != HW_TRAP_NUM[4];
  endproperty
  a_nest: assert property (p_nest)
    else $error("lower trap preempted a trap service");
  property p_ret;
    trap_return && trap_active && !vector_valid |=> !trap_active;
  endproperty
  a_ret: assert property (p_ret)
    else $error("trap service did not end");
endmodule
bind interrupt_vector_trap_unit ivt_chk u_chk (.clk, .reset_n, .addr, .wdata, .wr_en,
  .hw_trap_in, .cpu_level, .vector_ack, .trap_return, .vector_valid, .vector_addr,
  .vector_num, .vector_is_trap, .vector_level, .trap_active, .xfer_block);

// >>> tb/cpu_core_model.sv
// Behavioural CPU core that takes vectors and ends trap services
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic       clk,            // Clock
  input  wire logic       reset_n,        // Reset
  input  wire logic       vector_valid,   // Offer
  input  wire logic       vector_is_trap, // Offer is a trap
  input  wire logic [3:0] ack_dly,        // Wait before taking
  input  wire logic [7:0] svc_len,        // Trap service length
  output logic            vector_ack,     // Take pulse
  output logic            trap_return     // End of trap service
);
  logic [3:0] cnt_r;
  logic [7:0] svc_cnt_r;
  logic       in_svc_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r       <= 4'h0;
      svc_cnt_r   <= 8'h00;
      in_svc_r    <= 1'b0;
      vector_ack  <= 1'b0;
      trap_return <= 1'b0;
    end else begin
      vector_ack  <= 1'b0;
      trap_return <= 1'b0;
      if (in_svc_r) begin
        svc_cnt_r <= svc_cnt_r + 8'h01;
        if (svc_cnt_r == svc_len) begin
          trap_return <= 1'b1;
          in_svc_r    <= 1'b0;
        end
      end
      // One take per offer; a nested trap restarts the service
      if (vector_valid && !vector_ack) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == ack_dly) begin
          vector_ack <= 1'b1;
          cnt_r      <= 4'h0;
          if (vector_is_trap) begin
            in_svc_r  <= 1'b1;
            svc_cnt_r <= 8'h00;
          end
        end
      end
    end
  end
endmodule

// >>> tb/interrupt_vector_trap_unit_tb.sv
// Self-checking bench of the vector and trap unit
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("wrong value at %0t: got %h, expected %h", $time, g, e); \
    end \
  end
module interrupt_vector_trap_unit_tb;
  import ivt_pkg::*;
  localparam logic [TNUM_W-1:0] TRAP_EXP [8] = '{7'h02, 7'h04, 7'h06, 7'h08,
    7'h0a, 7'h0a, 7'h0a, 7'h0a};
  localparam logic [TNUM_W-1:0] NODE_EXP [8] = '{7'h20, 7'h21, 7'h2b, 7'h4c,
    7'h54, 7'h55, 7'h56, 7'h57};
  logic                 clk, reset_n, wr_en, rd_en, irq;
  logic                 vector_ack, trap_return, vector_valid, vector_is_trap;
  logic                 trap_active, xfer_block;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdata, rdata;
  logic [NUM_NODES-1:0] node_req_in;
  logic [NUM_TRAPS-1:0] hw_trap_in;
  logic [LVL_W-1:0]     cpu_level, vector_level;
  logic [23:0]          vector_addr;
  logic [TNUM_W-1:0]    vector_num;
  logic [3:0]           ack_dly;
  logic [7:0]           svc_len;
  logic [SEG_W-1:0]     seg;
  int                   err_count, cmp_count, cyc;
  interrupt_vector_trap_unit uut (.clk, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .node_req_in, .hw_trap_in, .cpu_level, .vector_ack, .trap_return, .vector_valid,
    .vector_addr, .vector_num, .vector_is_trap, .vector_level, .trap_active,
    .xfer_block, .irq);
  cpu_core_model cpu (.clk, .reset_n, .vector_valid, .vector_is_trap, .ack_dly, .svc_len,
    .vector_ack, .trap_return);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [23:0] ea(input logic [TNUM_W-1:0] n, input int s);
    return {seg, 16'(n) << (SPC_SHIFT + s)};
  endfunction
  function automatic logic [ADDR_W-1:0] na(input int i);
    return ADR_NODE0 + ADR_NODE_STP * 8'(i);
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, e)
    // Read data must fall back to zero after their one cycle
    @(posedge clk);
    #1;
    `CHK(rdata, 16'h0000)
  endtask
  task automatic trap(input int i);
    @(posedge clk);
    hw_trap_in[i] <= 1'b1;
    @(posedge clk);
    hw_trap_in <= '0;
  endtask
  // Waits for one offer, checks it, then lets the core model take it
  task automatic offer(input logic [TNUM_W-1:0] n, input logic [23:0] a, input logic t,
                       input logic [LVL_W-1:0] l);
    int k;
    k = 0;
    while (vector_valid !== 1'b1 && k < 200) begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK(vector_valid, 1'b1)
    `CHK(vector_num, n)
    `CHK(vector_addr, a)
    `CHK(vector_is_trap, t)
    `CHK(vector_level, l)
    while (vector_valid === 1'b1) begin
      @(posedge clk);
      #1;
    end
  endtask
  // Fixed window in which no offer may appear
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      `CHK(vector_valid, 1'b0)
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    {reset_n, wr_en, rd_en, addr, wdata, node_req_in, hw_trap_in, cpu_level} = '0;
    ack_dly = 4'h0;
    svc_len = 8'd20;
    seg = 8'h5a;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADR_CPUCFG1, 16'h0000);
    wr(8'h40, 16'hffff);
    rd(8'h40, 16'h0000);
    wr(ADR_VSEG, {8'h00, seg});
    for (int i = 0; i < NUM_TRAPS; i++) begin
      trap(i);
      offer(TRAP_EXP[i], ea(TRAP_EXP[i], 0), 1'b1, 4'h0);
      `CHK(xfer_block, 1'b1)
      rd(ADR_TRAPFLAG, 16'(1 << i));
      while (trap_active === 1'b1) @(negedge clk);
      rd(ADR_TRAPFLAG, 16'(1 << i));
      wr(ADR_TRAPFLAG, 16'(1 << i));
      rd(ADR_TRAPFLAG, 16'h0000);
    end
    for (int i = 0; i < NUM_NODES; i++) begin
      wr(ADR_CPUCFG1, 16'(i % 4));
      wr(na(i), 16'h00c0 | 16'(i + 1));
      offer(NODE_EXP[i], ea(NODE_EXP[i], i % 4), 1'b0, 4'(i + 1));
      rd(na(i), 16'h0040 | 16'(i + 1));
    end
    wr(ADR_IRQMASK, 16'h0002);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b1)
    wr(ADR_IRQSTAT, 16'h0002);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b0)
    rd(ADR_IRQSTAT, 16'h0001);
    wr(ADR_CPUCFG1, 16'h0000);
    cpu_level <= 4'h5;
    ack_dly <= 4'h3;
    wr(na(0), 16'h00c5);
    quiet(12);
    wr(na(1), 16'h00c6);
    offer(NODE_EXP[1], ea(NODE_EXP[1], 0), 1'b0, 4'h6);
    @(posedge clk);
    cpu_level <= 4'h0;
    offer(NODE_EXP[0], ea(NODE_EXP[0], 0), 1'b0, 4'h5);
    svc_len <= 8'd80;
    wr(na(0), 16'h0049);
    trap(4);
    offer(7'h0a, ea(7'h0a, 0), 1'b1, 4'h0);
    @(posedge clk);
    node_req_in[0] <= 1'b1;
    trap(5);
    node_req_in <= '0;
    quiet(10);
    trap(1);
    offer(7'h04, ea(7'h04, 0), 1'b1, 4'h0);
    offer(7'h0a, ea(7'h0a, 0), 1'b1, 4'h0);
    offer(NODE_EXP[0], ea(NODE_EXP[0], 0), 1'b0, 4'h9);
    rd(ADR_TRAPFLAG, 16'h0032);
    tally_and_finish();
  end
endmodule
